/* verilog/fifo_offset_consts.vh */
// Constants for the offset load, readback and retransmit FIFO block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef FIFO_OFFSET_CONSTS_VH
`define FIFO_OFFSET_CONSTS_VH

// Data path and offset widths.
`define DATA_W            18
`define OFF_W             16

// Storage FIFO geometry.
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define FIFO_HALF         4'd4

// Offset register selectors for the write and read pointers.
`define OFF_SEL_EMPTY     1'b0
`define OFF_SEL_FULL      1'b1
`define OFF_REGS          2

// Offset defaults chosen by the load select strap at master reset.
`define OFF_DEF_PARALLEL  16'h007f
`define OFF_DEF_SERIAL    16'h03ff

// Flag synchroniser stages and retransmit setup length in cycles.
`define FLAG_SYNC_STAGES  2
`define RT_SETUP_CYCLES   2'd2

`endif

/* verilog/fifo_offset_load_retransmit.v */
// Offset register parallel load and readback with retransmit, in front of
// a small storage FIFO. Assumes the controller runs on i_ref_clk, so only
// the partial reset pin is treated as asynchronous and synchronised.
//
// Overview of operation
// - Load low and write strobe low store data: empty offset, full, wrap.
// - Offset write pointer and offset read pointer advance independently.
// - Master reset returns both offset pointers to the empty offset.
// - Partial reset leaves both offset pointers where they are.
// - Load high sends writes to memory; load low resumes offset sequence.
// - Almost-full held inactive from an empty offset write until its own is written.
// - Almost-full valid two edges after write; almost-empty likewise.
// - Load low and read strobe low drive offsets out: empty, full, wrap.
// - Paused readback resumes at the register where it stopped.
// - Offset readback overwrites the word shown on the data outputs.
// - Offset readback works in standard and fall-through modes.
// - Retransmit setup starts when retransmit request is low at an edge.
// - Standard mode: empty low during setup, every read then needs a strobe.
// - Fall-through: output ready high in setup, first word then shown.
// - Half-full updates on the edge that captures retransmit setup.
// - Almost-empty updates on the second edge after retransmit setup.
// - Almost-full updates on the second edge after retransmit setup.
// - Data input and output buses are eighteen bits wide.
// - Load strap low gives offsets 127, high gives 1023.
// - Each offset register is sixteen bits wide.
// - Fall-through strap at master reset picks the timing mode.
`timescale 1ns/1ns
`include "fifo_offset_consts.vh"

// Storage FIFO with valid and ready on both sides, a clear and a rewind.
module offset_store_fifo #(
	parameter W     = 18,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock, reset, clear and rewind.
	input  wire          i_clk,
	input  wire          i_rst,
	input  wire          i_clear,
	input  wire          i_rewind,
	// Filling side.
	input  wire          i_wr_valid,
	output wire          o_wr_ready,
	input  wire [W-1:0]  i_wr_data,
	// Draining side.
	output wire          o_rd_valid,
	input  wire          i_rd_ready,
	output wire [W-1:0]  o_rd_data,
	// Occupancy.
	output wire [AW:0]   o_count
);
	reg [W-1:0]  mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0]   count_q;
	wire         push;
	wire         pop;

	// Full and empty come straight from the occupancy count.
	assign o_wr_ready = (count_q != DEPTH[AW:0]);
	assign o_rd_valid = (count_q != {(AW+1){1'b0}});
	assign push       = i_wr_valid & o_wr_ready;
	assign pop        = i_rd_ready & o_rd_valid;
	assign o_rd_data  = mem_q[rd_ptr_q];
	assign o_count    = count_q;

	// Memory array is not reset; only pointers and count carry state that matters.
	always @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_wr_data;
		end
	end

	// Rewind replays from location zero; the count becomes the number of
	// words written, which holds only while the write pointer never wrapped.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else if (i_clear) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else if (i_rewind) begin
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {1'b0, wr_ptr_q};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // offset_store_fifo

module fifo_offset_load_retransmit (
	// Clock and master reset.
	input  wire               i_ref_clk,
	input  wire               i_rst,
	// Asynchronous partial reset pin.
	input  wire               i_partial_reset_low,
	// Straps sampled at master reset release.
	input  wire               i_fall_through_mode,
	// Write side controls and data.
	input  wire               i_wr_strobe_low,
	input  wire               i_offset_load_select_low,
	input  wire [`DATA_W-1:0] i_data_in_bus,
	// Read side controls.
	input  wire               i_rd_strobe_low,
	input  wire               i_retransmit_request_low,
	// Data output.
	output wire [`DATA_W-1:0] o_data_out_bus,
	// Status flags.
	output wire               o_empty_flag_low,
	output wire               o_full_flag_low,
	output wire               o_half_full_flag_low,
	output wire               o_almost_empty_flag_low,
	output wire               o_almost_full_flag_low,
	output wire               o_fall_through_mode
);
	// Decoded active levels of the strobes.
	wire wen_act;
	wire ren_act;
	wire ld_act;
	wire rt_act;
	assign wen_act = ~i_wr_strobe_low;
	assign ren_act = ~i_rd_strobe_low;
	assign ld_act  = ~i_offset_load_select_low;
	assign rt_act  = ~i_retransmit_request_low;

	// Partial reset synchroniser; only the second stage is used.
	reg prst_meta_q;
	reg prst_q;
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			prst_meta_q <= 1'b0;
			prst_q      <= 1'b0;
		end else begin
			prst_meta_q <= ~i_partial_reset_low;
			prst_q      <= prst_meta_q;
		end
	end

	// Straps are caught on the first edge after master reset release, since
	// an asynchronous reset may only load constants.
	reg init_q;
	reg fall_through_mode_q;
	reg serial_q;
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			init_q   <= 1'b1;
			fall_through_mode_q   <= 1'b0;
			serial_q <= 1'b0;
		end else if (init_q) begin
			init_q   <= 1'b0;
			fall_through_mode_q   <= i_fall_through_mode;
			serial_q <= ~ld_act;
		end
	end
	assign o_fall_through_mode = fall_through_mode_q;

	// Offset pointers and write decode.
	reg  off_wr_ptr_q;
	reg  off_rd_ptr_q;
	wire off_wr;
	wire off_rd;
	reg  [`OFF_W-1:0] off_q [0:`OFF_REGS-1];
	reg  [`OFF_REGS-1:0] off_written_q;

	// Parallel loading is only honoured when the strap chose it.
	// Serial loading is not built, so a serial strap keeps the defaults.
	assign off_wr = wen_act & ld_act & ~serial_q & ~init_q;
	assign off_rd = ren_act & ld_act & ~init_q;

	// The write and read paths each have their own offset pointer and
	// never share one, so a paused readback is not disturbed by loading.
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			off_wr_ptr_q <= `OFF_SEL_EMPTY;
			off_rd_ptr_q <= `OFF_SEL_EMPTY;
		end else begin
			// Partial reset is deliberately absent here.
			if (off_wr) begin
				off_wr_ptr_q <= ~off_wr_ptr_q;
			end
			if (off_rd) begin
				off_rd_ptr_q <= ~off_rd_ptr_q;
			end
		end
	end

	// One offset register per flag, loaded from the low data bits.
	genvar gi;
	generate
		for (gi = 0; gi < `OFF_REGS; gi = gi + 1) begin : g_off
			always @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					off_q[gi]         <= `OFF_DEF_PARALLEL;
					off_written_q[gi] <= 1'b1;
				end else if (init_q) begin
					if (~ld_act) begin
						off_q[gi] <= `OFF_DEF_SERIAL;
					end
				end else if (off_wr && (off_wr_ptr_q == gi)) begin
					off_q[gi]         <= i_data_in_bus[`OFF_W-1:0];
					off_written_q[gi] <= 1'b1;
				end else if (off_wr) begin
					// Programming the empty register makes the almost-full flag
					// untrustworthy until its own register is written; almost-empty is kept.
					off_written_q[gi] <= off_written_q[gi] & (gi == 0);
				end
			end
		end
	endgenerate

	// Retransmit setup sequencing.
	// A request that arrives while setup runs is ignored, not queued.
	reg  [1:0] rt_cnt_q;
	wire       rt_busy;
	wire       rt_start;
	assign rt_busy  = (rt_cnt_q != 2'd0);
	assign rt_start = rt_act & ~rt_busy & ~init_q & ~prst_q;

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rt_cnt_q <= 2'd0;
		end else if (prst_q) begin
			rt_cnt_q <= 2'd0;
		end else if (rt_start) begin
			rt_cnt_q <= `RT_SETUP_CYCLES;
		end else if (rt_busy) begin
			rt_cnt_q <= rt_cnt_q - 2'd1;
		end
	end

	// Storage FIFO hookup; memory writes only while load select is high.
	wire                fifo_wr_valid;
	wire                fifo_wr_ready;
	wire                fifo_rd_valid;
	wire                fifo_rd_ready;
	wire [`DATA_W-1:0]  fifo_rd_data;
	wire [`FIFO_AW:0]   fifo_count;
	assign fifo_wr_valid = wen_act & ~ld_act & ~init_q & ~prst_q;

	offset_store_fifo #(
		.W     (`DATA_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_store (
		.i_clk      (i_ref_clk),
		.i_rst      (i_rst),
		.i_clear    (prst_q),
		.i_rewind   (rt_start),
		.i_wr_valid (fifo_wr_valid),
		.o_wr_ready (fifo_wr_ready),
		.i_wr_data  (i_data_in_bus),
		.o_rd_valid (fifo_rd_valid),
		.i_rd_ready (fifo_rd_ready),
		.o_rd_data  (fifo_rd_data),
		.o_count    (fifo_count)
	);

	// Output register and its valid bit for fall-through presentation.
	// Partial reset clears the shown word but never the offset registers.
	reg [`DATA_W-1:0] dout_q;
	reg               out_valid_q;
	wire              mem_rd_std;
	wire              mem_rd_fall_through_mode;

	// Standard mode pops only on a strobe; fall-through also refills an
	// empty output register by itself, which shows the first word at once.
	assign mem_rd_std  = ~fall_through_mode_q & ren_act & ~ld_act;
	assign mem_rd_fall_through_mode = fall_through_mode_q & (~out_valid_q | (ren_act & ~ld_act));
	// An offset readback owns the output register for that edge, so an
	// automatic refill is held off rather than popping a word that would
	// then be lost behind the offset value.
	assign fifo_rd_ready = (mem_rd_std | mem_rd_fall_through_mode) & ~rt_busy & ~rt_start &
		~init_q & ~prst_q & ~off_rd;

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dout_q      <= {`DATA_W{1'b0}};
			out_valid_q <= 1'b0;
		end else if (prst_q) begin
			dout_q      <= {`DATA_W{1'b0}};
			out_valid_q <= 1'b0;
		end else if (rt_start) begin
			out_valid_q <= 1'b0;
		end else if (off_rd) begin
			// Offsets zero-extend and overwrite the shown word.
			dout_q <= {{(`DATA_W-`OFF_W){1'b0}}, off_q[off_rd_ptr_q]};
		end else if (fifo_rd_ready & fifo_rd_valid) begin
			dout_q      <= fifo_rd_data;
			out_valid_q <= 1'b1;
		end else if (mem_rd_fall_through_mode & ~rt_busy & ~init_q) begin
			out_valid_q <= 1'b0;
		end
	end
	assign o_data_out_bus = dout_q;

	// Empty or output-ready pin, full or input-ready pin, by timing mode.
	assign o_empty_flag_low = fall_through_mode_q ? ~(out_valid_q & ~rt_busy) :
		(fifo_rd_valid & ~rt_busy);
	assign o_full_flag_low  = fall_through_mode_q ? ~fifo_wr_ready : fifo_wr_ready;

	// Half full follows the count directly, so the rewind edge updates it.
	// Being combinational it may settle late in the cycle; sample it on
	// the clock rather than asynchronously.
	assign o_half_full_flag_low = ~(fifo_count > `FIFO_HALF);

	// Almost flags: compare, then two pipeline stages; almost-full is held
	// inactive from an empty offset write until the full offset is written.
	wire [`OFF_W:0] cnt_ext;
	wire            ae_raw;
	wire            af_raw;
	reg  [`FLAG_SYNC_STAGES-1:0] ae_pipe_q;
	reg  [`FLAG_SYNC_STAGES-1:0] af_pipe_q;
	assign cnt_ext = {{(`OFF_W-`FIFO_AW){1'b0}}, fifo_count};
	assign ae_raw  = off_written_q[`OFF_SEL_EMPTY] &
		(cnt_ext <= {1'b0, off_q[`OFF_SEL_EMPTY]});
	assign af_raw  = off_written_q[`OFF_SEL_FULL] &
		((cnt_ext + {1'b0, off_q[`OFF_SEL_FULL]}) >=
		`FIFO_DEPTH);

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ae_pipe_q <= {`FLAG_SYNC_STAGES{1'b1}};
			af_pipe_q <= {`FLAG_SYNC_STAGES{1'b0}};
		end else begin
			ae_pipe_q <= {ae_pipe_q[`FLAG_SYNC_STAGES-2:0], ae_raw};
			af_pipe_q <= {af_pipe_q[`FLAG_SYNC_STAGES-2:0], af_raw};
		end
	end
	assign o_almost_empty_flag_low = ~ae_pipe_q[`FLAG_SYNC_STAGES-1];
	assign o_almost_full_flag_low  = ~af_pipe_q[`FLAG_SYNC_STAGES-1];
endmodule // fifo_offset_load_retransmit

/* dv/fifo_offset_load_retransmit_properties.sv */
// Checker on the ports of the offset load and retransmit block.
// Assumes one clock for both sides; bound onto every instance.
`timescale 1ns/1ns
`include "fifo_offset_consts.vh"

module fifo_offset_checker (
	// Clock, resets and strap.
	input wire               i_ref_clk,
	input wire               i_rst,
	input wire               i_partial_reset_low,
	input wire               i_fall_through_mode,
	// Controls and data.
	input wire               i_wr_strobe_low,
	input wire               i_offset_load_select_low,
	input wire [`DATA_W-1:0] i_data_in_bus,
	input wire               i_rd_strobe_low,
	input wire               i_retransmit_request_low,
	input wire [`DATA_W-1:0] o_data_out_bus,
	// Flags.
	input wire               o_empty_flag_low,
	input wire               o_full_flag_low,
	input wire               o_half_full_flag_low,
	input wire               o_almost_empty_flag_low,
	input wire               o_almost_full_flag_low,
	input wire               o_fall_through_mode
);
	reg  [3:0] quiet_q;
	wire       act;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// Any request or partial reset counts as a cause of change.
	assign act = !i_wr_strobe_low || !i_rd_strobe_low ||
		!i_retransmit_request_low || !i_partial_reset_low;

	// Saturating count of idle cycles, so settled outputs can be judged.
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			quiet_q <= 4'h0;
		else if (act)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end

	a_reset_state: assert property (disable iff (1'b0)
		i_rst |-> o_data_out_bus == 18'h0 && o_full_flag_low &&
		o_half_full_flag_low && !o_almost_empty_flag_low &&
		o_almost_full_flag_low && !o_fall_through_mode)
		else $error("reset state wrong");
	a_mode_hold: assert property (!$past(i_rst, 2) |->
		$stable(o_fall_through_mode)) else $error("mode changed");
	a_rdback_upper: assert property (
		!i_rd_strobe_low && !i_offset_load_select_low |->
		##[1:2] o_data_out_bus[17:16] == 2'b00)
		else $error("readback upper bits set");
	a_std_setup: assert property (
		!o_fall_through_mode && i_partial_reset_low &&
		$fell(i_retransmit_request_low) |=> !o_empty_flag_low ##1
		!o_empty_flag_low ##[1:2] o_empty_flag_low)
		else $error("standard setup timing");
	a_ft_setup: assert property (
		o_fall_through_mode && i_partial_reset_low &&
		$fell(i_retransmit_request_low) |=> o_empty_flag_low ##1
		o_empty_flag_low ##[1:3] !o_empty_flag_low)
		else $error("fall-through setup timing");
	a_half_cause: assert property ($changed(o_half_full_flag_low)
		|-> $past(act) || $past(act, 2) || $past(act, 3) ||
		$past(act, 4))
		else $error("half flag moved without cause");
	a_flags_settle: assert property (quiet_q >= 4'h6 |->
		$stable(o_almost_empty_flag_low) &&
		$stable(o_almost_full_flag_low)) else $error("almost flags late");
	a_data_hold: assert property (quiet_q >= 4'h8 |->
		$stable(o_data_out_bus) && $stable(o_empty_flag_low))
		else $error("output moved while idle");
endmodule // fifo_offset_checker

bind fifo_offset_load_retransmit fifo_offset_checker u_fifo_offset_checker (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_partial_reset_low(i_partial_reset_low),
	.i_fall_through_mode(i_fall_through_mode),
	.i_wr_strobe_low(i_wr_strobe_low),
	.i_offset_load_select_low(i_offset_load_select_low),
	.i_data_in_bus(i_data_in_bus), .i_rd_strobe_low(i_rd_strobe_low),
	.i_retransmit_request_low(i_retransmit_request_low),
	.o_data_out_bus(o_data_out_bus), .o_empty_flag_low(o_empty_flag_low),
	.o_full_flag_low(o_full_flag_low),
	.o_half_full_flag_low(o_half_full_flag_low),
	.o_almost_empty_flag_low(o_almost_empty_flag_low),
	.o_almost_full_flag_low(o_almost_full_flag_low),
	.o_fall_through_mode(o_fall_through_mode));

/* dv/ctrl_model.sv */
// Model of the external controller on both sides of the block.
// Assumes one clock; every request changes just after a rising edge.
`timescale 1ns/1ns
`include "fifo_offset_consts.vh"

module ctrl_model (
	// Clock.
	input  wire               i_ref_clk,
	// Requests toward the block.
	output reg                o_wr_strobe_low,
	output reg                o_offset_load_select_low,
	output reg [`DATA_W-1:0]  o_data_in_bus,
	output reg                o_rd_strobe_low,
	output reg                o_retransmit_request_low,
	output reg                o_partial_reset_low
);
	// Idle levels; load select low at first release straps parallel load.
	initial begin
		o_wr_strobe_low = 1'b1;
		o_offset_load_select_low = 1'b0;
		o_data_in_bus = 18'h0;
		o_rd_strobe_low = 1'b1;
		o_retransmit_request_low = 1'b1;
		o_partial_reset_low = 1'b1;
	end

	// One write; afterwards the bus shows the inverse, as stale data.
	task put(input sel_low, input [`DATA_W-1:0] d);
	begin
		@(posedge i_ref_clk);
		o_offset_load_select_low <= sel_low;
		o_wr_strobe_low <= 1'b0;
		o_data_in_bus <= d;
		@(posedge i_ref_clk);
		o_wr_strobe_low <= 1'b1;
		o_offset_load_select_low <= 1'b1;
		o_data_in_bus <= ~d;
	end
	endtask

	// One read; reads and writes never share a cycle.
	task get(input sel_low);
	begin
		@(posedge i_ref_clk);
		o_offset_load_select_low <= sel_low;
		o_rd_strobe_low <= 1'b0;
		@(posedge i_ref_clk);
		o_rd_strobe_low <= 1'b1;
		o_offset_load_select_low <= 1'b1;
	end
	endtask

	// Retransmit request; both strobes are already high here.
	task retx;
	begin
		@(posedge i_ref_clk);
		o_retransmit_request_low <= 1'b0;
		@(posedge i_ref_clk);
		o_retransmit_request_low <= 1'b1;
	end
	endtask

	// Partial reset pulse, long enough for the pin synchroniser.
	task preset;
	begin
		@(posedge i_ref_clk);
		o_partial_reset_low <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		o_partial_reset_low <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
	end
	endtask
endmodule // ctrl_model

/* dv/tb.sv */
// Self-checking bench for the offset load and retransmit block.
// Assumes the controller model drives every control input but master reset and the fall-through strap.
`timescale 1ns/1ns
`include "fifo_offset_consts.vh"

module tb;
	reg                clk;
	reg                rst;
	reg                ft;
	wire               wr_low, load_low, rd_low, retx_low, prs_low;
	wire [`DATA_W-1:0] din;
	wire [`DATA_W-1:0] dout;
	wire               empty_low, full_low, half_low, ae_low, af_low, ft_q;
	integer            mismatches, cmp_count, i;

	// 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	fifo_offset_load_retransmit u_fifo_offset_load_retransmit (
		.i_ref_clk(clk), .i_rst(rst), .i_partial_reset_low(prs_low),
		.i_fall_through_mode(ft), .i_wr_strobe_low(wr_low),
		.i_offset_load_select_low(load_low), .i_data_in_bus(din),
		.i_rd_strobe_low(rd_low), .i_retransmit_request_low(retx_low),
		.o_data_out_bus(dout), .o_empty_flag_low(empty_low),
		.o_full_flag_low(full_low), .o_half_full_flag_low(half_low),
		.o_almost_empty_flag_low(ae_low), .o_almost_full_flag_low(af_low),
		.o_fall_through_mode(ft_q));
	ctrl_model u_ctrl_model (.i_ref_clk(clk), .o_wr_strobe_low(wr_low),
		.o_offset_load_select_low(load_low), .o_data_in_bus(din),
		.o_rd_strobe_low(rd_low), .o_retransmit_request_low(retx_low),
		.o_partial_reset_low(prs_low));

	// Compares and counts; a miss is printed at once.
	task check(input string what, input [17:0] seen, input [17:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	task tick(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask

	task rdo(input [17:0] exp);
	begin
		u_ctrl_model.get(1'b0);
		tick(1);
		check("offset", dout, exp);
	end
	endtask

	task flags(input e, input h, input a, input f);
	begin
		tick(6);
		check("empty", empty_low, e);
		check("half", half_low, h);
		check("almost empty", ae_low, a);
		check("almost full", af_low, f);
	end
	endtask

	// Bounded wait for the empty or output-ready flag to reach a level.
	task wait_empty(input v);
	begin
		for (i = 0; i < 10 && empty_low !== v; i = i + 1)
			tick(1);
		check("setup end", empty_low, v);
	end
	endtask

	task end_sim;
	begin
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask

	// Offset writes wrap, memory writes interleave, readback resumes.
	task t_offsets;
	begin
		u_ctrl_model.put(1'b0, 18'h30003);
		u_ctrl_model.put(1'b0, 18'h00002);
		u_ctrl_model.put(1'b0, 18'h30004);
		u_ctrl_model.put(1'b1, 18'h00011);
		rdo(18'h4);
		rdo(18'h2);
		u_ctrl_model.get(1'b1);
		tick(1);
		check("memory", dout, 18'h11);
		rdo(18'h4);
	end
	endtask

	// Partial reset keeps offsets and both offset pointers.
	task t_partial;
	begin
		u_ctrl_model.preset;
		#1;
		check("cleared", dout, 18'h0);
		rdo(18'h2);
		u_ctrl_model.put(1'b0, 18'h5);
		rdo(18'h4);
		rdo(18'h5);
	end
	endtask

	// Standard retransmit after five words; offsets are empty 4, full 5.
	task t_retx;
	begin
		for (int k = 0; k < 5; k++)
			u_ctrl_model.put(1'b1, 18'h100 + k);
		flags(1'b1, 1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 5; k++) begin
			u_ctrl_model.get(1'b1);
			tick(1);
			check("read", dout, 18'h100 + k);
		end
		flags(1'b0, 1'b1, 1'b0, 1'b1);
		u_ctrl_model.retx;
		#1;
		check("setup empty", empty_low, 1'b0);
		check("setup half", half_low, 1'b0);
		wait_empty(1'b1);
		tick(4);
		check("rt almost empty", ae_low, 1'b1);
		check("rt almost full", af_low, 1'b0);
		u_ctrl_model.get(1'b1);
		tick(1);
		check("first again", dout, 18'h100);
	end
	endtask

	// Fill until refused, then drain until empty.
	task t_fill;
	begin
		u_ctrl_model.preset;
		for (int k = 0; k < 9; k++)
			u_ctrl_model.put(1'b1, 18'h200 + k);
		tick(1);
		check("full", full_low, 1'b0);
		for (int k = 0; k < 8; k++) begin
			u_ctrl_model.get(1'b1);
			tick(1);
			check("drain", dout, 18'h200 + k);
		end
		u_ctrl_model.get(1'b1);
		tick(2);
		check("empty read", dout, 18'h207);
	end
	endtask

	// Fall-through mode with serial strap: defaults, readback, retransmit.
	task t_ft;
	begin
		@(posedge clk);
		rst <= 1'b1;
		ft <= ~ft; // Second pass uses the other timing strap.
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		check("mode", ft_q, 1'b1);
		u_ctrl_model.put(1'b1, 18'h300);
		u_ctrl_model.put(1'b1, 18'h301);
		tick(6);
		check("fall through", dout, 18'h300);
		check("input ready", full_low, 1'b0);
		rdo(18'h3ff);
		u_ctrl_model.put(1'b0, 18'h9);
		rdo(18'h3ff);
		rdo(18'h3ff);
		u_ctrl_model.retx;
		#1;
		check("setup ready", empty_low, 1'b1);
		wait_empty(1'b0);
		check("first shown", dout, 18'h300);
	end
	endtask

	// Main sequence.
	initial begin
		mismatches = 0;
		cmp_count = 0;
		// Raise reset off the edge so the design sees a clean rising level.
		rst = 1'b0;
		ft = 1'b0;
		#1 rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		rdo(18'h7f);
		rdo(18'h7f);
		t_offsets;
		t_partial;
		t_retx;
		t_fill;
		t_ft;
		end_sim;
	end

	// Watchdog against a hang.
	initial begin
		#100000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule // tb
